// ==== rtl/iomsf_defines.vh ====
/*
 * Constants for the I/O and miscellaneous status flag group: flag bit
 * positions, widths, reset values and timing counts.
 * Assumes a 20 MHz system clock and inclusion by bare name.
 */
`ifndef IOMSF_DEFINES_VH
`define IOMSF_DEFINES_VH

// Flag bit positions
`define IOMSF_BIT_HSS3_SHORT     0
`define IOMSF_BIT_HSS2_SHORT     1
`define IOMSF_BIT_SPI_PARITY     2
`define IOMSF_BIT_SEL_STUCK      3
`define IOMSF_BIT_SUPPLY2_UV     4
`define IOMSF_BIT_SUPPLY1_OV     5
`define IOMSF_BIT_HSS0_HOT       6
`define IOMSF_BIT_WD_FLASH_HALF  7
`define IOMSF_BIT_WAKE_IO13      8
`define IOMSF_BIT_WAKE_IO02      9
`define IOMSF_BIT_SPI_WAKE       10
`define IOMSF_BIT_FORCED_WAKE    11
`define IOMSF_BIT_INT_TIMEOUT    12
`define IOMSF_BIT_LP_REG_OFF     13
`define IOMSF_BIT_RESET_REQ      14
`define IOMSF_BIT_DEBUG_HW_EXIT  15

`define IOMSF_FLAGS_W            16
`define IOMSF_FLAGS_RESET        16'h0000
`define IOMSF_WAKE_PINS          4
`define IOMSF_WD_W               16

// Timing
`define IOMSF_CLK_PERIOD_NS      50
`define IOMSF_SEL_LOW_LIMIT_NS   2000000
`define IOMSF_SEL_STUCK_CYC      (`IOMSF_SEL_LOW_LIMIT_NS / `IOMSF_CLK_PERIOD_NS)
`define IOMSF_INT_TIMEOUT_CYC    2000
`define IOMSF_TIMER_W            17

`endif

// ==== rtl/iomsf_flags.v ====
/*
 * I/O and miscellaneous status flag group: latches switch faults, SPI
 * faults, battery supply faults, watchdog progress in flash mode, wake
 * sources, interrupt timeout, low-power entry, reset request and debug
 * exit, and returns them to the SPI core with clear-on-read.
 * Assumes the SPI core gives one read strobe per flag-group read and that
 * the analog comparators deliver clean levels synchronous to the clock.
 */
`timescale 1ns/1ns
`include "iomsf_defines.vh"

module iomsf_flags #(
    parameter integer SEL_STUCK_CYC = `IOMSF_SEL_STUCK_CYC,
    parameter integer INT_TIMEOUT_CYC = `IOMSF_INT_TIMEOUT_CYC,
    parameter integer WD_W = `IOMSF_WD_W
) (
    input  wire                       SYS_CLK_IN,                 // System clock, 20 MHz
    input  wire                       SYS_RST_IN,                 // Synchronous reset, active high
    input  wire                       HIGH_SIDE_SWITCH3_SHORT_IN, // I/O-3 switch shorted to ground
    input  wire                       HIGH_SIDE_SWITCH2_SHORT_IN, // I/O-2 switch shorted to ground
    input  wire                       SPI_PARITY_ERR_IN,          // Pulse: frame parity failed
    input  wire                       SPI_SELECT_BAR_IN,          // SPI select, active low
    input  wire                       BATTERY_SUPPLY_TWO_LOW_IN,  // Supply two below low limit
    input  wire                       BATTERY_SUPPLY_ONE_HIGH_IN, // Supply one above high limit
    input  wire                       HIGH_SIDE_SWITCH0_HOT_IN,   // I/O-0 switch over temperature
    input  wire                       FLASH_MODE_IN,              // Flash programming mode active
    input  wire [WD_W-1:0]            WD_ELAPSED_IN,              // Watchdog cycles elapsed
    input  wire [WD_W-1:0]            WD_PERIOD_IN,               // Watchdog programmed period
    input  wire [`IOMSF_WAKE_PINS-1:0] WAKE_IO_IN,                // Pulses: wake seen per I/O pin
    input  wire                       SPI_WAKE_IN,                // Pulse: SPI wake command
    input  wire                       LOW_POWER_REGULATOR_ON_IN,  // In low power, regulator on
    input  wire                       FORCED_WAKE_IN,             // Pulse: timer forced wake
    input  wire                       INT_ASSERTED_IN,            // Interrupt output asserted
    input  wire                       LOW_POWER_REGULATOR_OFF_IN, // Pulse: regulator-off mode chosen
    input  wire                       SPI_RESET_REQ_IN,           // Pulse: SPI asks for reset mode
    input  wire                       RESET_MODE_IN,              // Device in reset mode
    input  wire                       DEBUG_MODE_IN,              // Device in debug mode
    input  wire                       DEBUG_ENTRY_PIN_LOW_IN,     // Debug pin below exit voltage
    input  wire                       READ_STB_IN,                // Pulse: host reads flag group
    output reg  [`IOMSF_FLAGS_W-1:0]  FLAGS_OUT,                  // Live latched flags
    output reg  [`IOMSF_FLAGS_W-1:0]  READ_DATA_OUT,              // Flags captured at read
    output reg                        READ_VALID_OUT              // Pulse: capture done
);
    localparam integer FW = `IOMSF_FLAGS_W;

    // Next flag value; the set wins over a clear in the same cycle
    function flag_next;
        input cur;
        input set;
        input cause;
        input rd;
        begin
            flag_next = set | (cur & ~(rd & ~cause));
        end
    endfunction

    // Rising edge of a sampled level
    function rise;
        input now;
        input last;
        begin
            rise = now & ~last;
        end
    endfunction

    // Falling edge of a sampled level
    function fall;
        input now;
        input last;
        begin
            fall = ~now & last;
        end
    endfunction

    // Elapsed count strictly beyond half of the period
    function past_half;
        input [WD_W-1:0] elapsed;
        input [WD_W-1:0] period;
        begin
            past_half = {elapsed, 1'b0} > {1'b0, period};
        end
    endfunction

    reg  [FW-1:0] flags_r;
    reg  [FW-1:0] flags_nxt;
    reg  [FW-1:0] set_vec;
    reg  [FW-1:0] cause_vec;
    reg           wd_half_last_r;
    reg           reset_mode_last_r;
    reg           debug_mode_last_r;
    reg           reset_req_seen_r;
    reg           reset_req_seen_nxt;
    wire          sel_stuck;
    wire          int_timeout;
    wire          wd_half;
    wire          wd_half_cross;
    wire          reset_mode_fall;
    wire          debug_fall;
    integer       i;

    iomsf_level_timer #(
        .LIMIT (SEL_STUCK_CYC),
        .CW    (`IOMSF_TIMER_W)
    ) u_sel_timer (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (SYS_RST_IN),
        .level_in   (~SPI_SELECT_BAR_IN),
        .expire_out (sel_stuck)
    );

    iomsf_level_timer #(
        .LIMIT (INT_TIMEOUT_CYC),
        .CW    (`IOMSF_TIMER_W)
    ) u_int_timer (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (SYS_RST_IN),
        .level_in   (INT_ASSERTED_IN),
        .expire_out (int_timeout)
    );

    // Flash mode watchdog past half, and its crossing
    assign wd_half         = FLASH_MODE_IN & past_half(WD_ELAPSED_IN, WD_PERIOD_IN);
    assign wd_half_cross   = rise(wd_half, wd_half_last_r);

    // Mode exits seen in the same cycle the mode input drops, against its last sample
    assign reset_mode_fall = fall(RESET_MODE_IN, reset_mode_last_r);
    assign debug_fall      = fall(DEBUG_MODE_IN, debug_mode_last_r);

    always @* begin
        set_vec   = {FW{1'b0}};
        cause_vec = {FW{1'b0}};

        set_vec[`IOMSF_BIT_HSS3_SHORT]    = HIGH_SIDE_SWITCH3_SHORT_IN;
        cause_vec[`IOMSF_BIT_HSS3_SHORT]  = HIGH_SIDE_SWITCH3_SHORT_IN;
        set_vec[`IOMSF_BIT_HSS2_SHORT]    = HIGH_SIDE_SWITCH2_SHORT_IN;
        cause_vec[`IOMSF_BIT_HSS2_SHORT]  = HIGH_SIDE_SWITCH2_SHORT_IN;

        set_vec[`IOMSF_BIT_SPI_PARITY]    = SPI_PARITY_ERR_IN;
        set_vec[`IOMSF_BIT_SEL_STUCK]     = sel_stuck;

        set_vec[`IOMSF_BIT_SUPPLY2_UV]    = BATTERY_SUPPLY_TWO_LOW_IN;
        cause_vec[`IOMSF_BIT_SUPPLY2_UV]  = BATTERY_SUPPLY_TWO_LOW_IN;
        set_vec[`IOMSF_BIT_SUPPLY1_OV]    = BATTERY_SUPPLY_ONE_HIGH_IN;
        cause_vec[`IOMSF_BIT_SUPPLY1_OV]  = BATTERY_SUPPLY_ONE_HIGH_IN;
        set_vec[`IOMSF_BIT_HSS0_HOT]      = HIGH_SIDE_SWITCH0_HOT_IN;
        cause_vec[`IOMSF_BIT_HSS0_HOT]    = HIGH_SIDE_SWITCH0_HOT_IN;

        // Crossing only, so a read can clear while still past half
        set_vec[`IOMSF_BIT_WD_FLASH_HALF] = wd_half_cross;

        set_vec[`IOMSF_BIT_WAKE_IO13]     = WAKE_IO_IN[1] | WAKE_IO_IN[3];
        set_vec[`IOMSF_BIT_WAKE_IO02]     = WAKE_IO_IN[0] | WAKE_IO_IN[2];
        set_vec[`IOMSF_BIT_SPI_WAKE]      = SPI_WAKE_IN & LOW_POWER_REGULATOR_ON_IN;
        set_vec[`IOMSF_BIT_FORCED_WAKE]   = FORCED_WAKE_IN;
        set_vec[`IOMSF_BIT_INT_TIMEOUT]   = int_timeout;
        set_vec[`IOMSF_BIT_LP_REG_OFF]    = LOW_POWER_REGULATOR_OFF_IN;

        // Flag raised as reset mode ends after an SPI request
        set_vec[`IOMSF_BIT_RESET_REQ]     = reset_req_seen_r & reset_mode_fall;

        // Debug left while the pin is below its exit voltage
        set_vec[`IOMSF_BIT_DEBUG_HW_EXIT] = debug_fall & DEBUG_ENTRY_PIN_LOW_IN;
    end

    always @* begin
        flags_nxt = flags_r;
        for (i = 0; i < FW; i = i + 1) begin
            flags_nxt[i] = flag_next(flags_r[i], set_vec[i], cause_vec[i], READ_STB_IN);
        end
    end

    always @* begin
        reset_req_seen_nxt = reset_req_seen_r;
        if (SPI_RESET_REQ_IN)
            reset_req_seen_nxt = 1'b1;
        else if (reset_mode_fall)
            reset_req_seen_nxt = 1'b0;
    end

    always @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            flags_r           <= `IOMSF_FLAGS_RESET;
            wd_half_last_r    <= 1'b0;
            reset_mode_last_r <= 1'b0;
            debug_mode_last_r <= 1'b0;
            reset_req_seen_r  <= 1'b0;
        end else begin
            flags_r           <= flags_nxt;
            wd_half_last_r    <= wd_half;
            reset_mode_last_r <= RESET_MODE_IN;
            debug_mode_last_r <= DEBUG_MODE_IN;
            reset_req_seen_r  <= reset_req_seen_nxt;
        end
    end

    // Read data is the pre-clear value of the same cycle
    always @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            FLAGS_OUT      <= `IOMSF_FLAGS_RESET;
            READ_DATA_OUT  <= `IOMSF_FLAGS_RESET;
            READ_VALID_OUT <= 1'b0;
        end else begin
            FLAGS_OUT      <= flags_nxt;
            READ_VALID_OUT <= READ_STB_IN;
            if (READ_STB_IN)
                READ_DATA_OUT <= flags_r;
        end
    end
endmodule

// ==== rtl/iomsf_level_timer.v ====
/*
 * Level duration timer: counts cycles while a level is active and gives
 * one pulse when the level has stood longer than the limit.
 * Assumes the level is synchronous to the clock.
 */
`timescale 1ns/1ns
`include "iomsf_defines.vh"

module iomsf_level_timer #(
    parameter integer LIMIT = 16,
    parameter integer CW    = `IOMSF_TIMER_W
) (
    input  wire          clk_in,     // System clock
    input  wire          rst_in,     // Synchronous reset, active high
    input  wire          level_in,   // Level being timed
    output reg           expire_out  // One pulse when limit exceeded
);
    localparam [CW-1:0] LIMIT_C = LIMIT[CW-1:0];

    reg [CW-1:0] count_r;
    reg          done_r;

    always @(posedge clk_in) begin
        if (rst_in) begin
            count_r    <= {CW{1'b0}};
            done_r     <= 1'b0;
            expire_out <= 1'b0;
        end else if (!level_in) begin
            count_r    <= {CW{1'b0}};
            done_r     <= 1'b0;
            expire_out <= 1'b0;
        end else begin
            // Saturate; pulse once per active stretch
            if (count_r != LIMIT_C)
                count_r <= count_r + {{(CW-1){1'b0}}, 1'b1};
            expire_out <= (count_r == LIMIT_C) && !done_r;
            if (count_r == LIMIT_C)
                done_r <= 1'b1;
        end
    end
endmodule

// ==== verif/iomsf_flags_sva.sv ====
/* Checker for the flag group: read handshake, capture and set/keep/clear.
   Bound to iomsf_flags; one clock, synchronous reset. */
`timescale 1ns/1ns
module iomsf_flags_sva #(
    parameter integer SEL_STUCK_CYC = 40000
) (
    input wire        SYS_CLK_IN,                 // Clock
    input wire        SYS_RST_IN,                 // Reset
    input wire        HIGH_SIDE_SWITCH3_SHORT_IN, // Short
    input wire        SPI_PARITY_ERR_IN,          // Parity
    input wire        SPI_SELECT_BAR_IN,          // Select
    input wire        BATTERY_SUPPLY_TWO_LOW_IN,  // Undervoltage
    input wire [3:0]  WAKE_IO_IN,                 // Wake pins
    input wire        FORCED_WAKE_IN,             // Forced wake
    input wire        READ_STB_IN,                // Read
    input wire [15:0] FLAGS_OUT,                  // Flags
    input wire [15:0] READ_DATA_OUT,              // Captured
    input wire        READ_VALID_OUT              // Valid
);
    reg [16:0] sel_low_r;
    always @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN || SPI_SELECT_BAR_IN)
            sel_low_r <= 17'h00000;
        else if (sel_low_r != 17'h1ffff)
            sel_low_r <= sel_low_r + 17'h00001;
    end
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    AST_VALID: assert property (1'b1 |=> READ_VALID_OUT == $past(READ_STB_IN))
        else $error("valid does not follow read");
    AST_CAPTURE: assert property (READ_STB_IN |=> READ_DATA_OUT == $past(FLAGS_OUT))
        else $error("read data not pre-read flags");
    AST_DATA_HOLD: assert property (!READ_STB_IN |=> $stable(READ_DATA_OUT))
        else $error("read data changed without read");
    AST_SHORT3: assert property (HIGH_SIDE_SWITCH3_SHORT_IN |=> FLAGS_OUT[0])
        else $error("short flag not set");
    AST_PARITY: assert property (SPI_PARITY_ERR_IN |=> FLAGS_OUT[2])
        else $error("parity flag not set");
    AST_SEL_EARLY: assert property (sel_low_r < SEL_STUCK_CYC |-> !$rose(FLAGS_OUT[3]))
        else $error("select flag set too early");
    AST_UV_HOLD: assert property (FLAGS_OUT[4] && !(READ_STB_IN && !BATTERY_SUPPLY_TWO_LOW_IN) |=> FLAGS_OUT[4])
        else $error("undervoltage flag lost");
    AST_WAKE13: assert property (WAKE_IO_IN[1] || WAKE_IO_IN[3] |=> FLAGS_OUT[8])
        else $error("wake flag not set");
    AST_WAKE02_KEEP: assert property (FLAGS_OUT[9] && !READ_STB_IN |=> FLAGS_OUT[9])
        else $error("wake flag lost without read");
    AST_FORCED_CLEAR: assert property (READ_STB_IN && !FORCED_WAKE_IN |=> !FLAGS_OUT[11])
        else $error("forced wake flag not cleared");
    cover property (READ_STB_IN && FLAGS_OUT != 16'h0000);
    cover property ($rose(FLAGS_OUT[3]));
    cover property (READ_STB_IN && SPI_PARITY_ERR_IN);
endmodule
bind iomsf_flags iomsf_flags_sva #(.SEL_STUCK_CYC(SEL_STUCK_CYC)) u_sva (
    .SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .HIGH_SIDE_SWITCH3_SHORT_IN(HIGH_SIDE_SWITCH3_SHORT_IN),
    .SPI_PARITY_ERR_IN(SPI_PARITY_ERR_IN), .SPI_SELECT_BAR_IN(SPI_SELECT_BAR_IN),
    .BATTERY_SUPPLY_TWO_LOW_IN(BATTERY_SUPPLY_TWO_LOW_IN), .WAKE_IO_IN(WAKE_IO_IN),
    .FORCED_WAKE_IN(FORCED_WAKE_IN), .READ_STB_IN(READ_STB_IN), .FLAGS_OUT(FLAGS_OUT),
    .READ_DATA_OUT(READ_DATA_OUT), .READ_VALID_OUT(READ_VALID_OUT));

// ==== verif/iomsf_host_model.sv ====
/* Host model: SPI master strobing flag reads and holding the select.
   Assumes the flag group answers at the edge after the strobe. */
`timescale 1ns/1ns
module iomsf_host_model (
    input  wire        clk_in,       // System clock
    input  wire [15:0] data_in,      // Captured flags
    input  wire        valid_in,     // Capture done
    output reg         read_stb_out, // Read strobe
    output reg         sel_bar_out   // Select, active low
);
    initial begin
        read_stb_out = 1'b0;
        sel_bar_out = 1'b1;
    end
    task read_flags(output [15:0] d, output v);
        begin
            @(posedge clk_in);
            #1;
            read_stb_out = 1'b1;
            @(posedge clk_in);
            #1;
            read_stb_out = 1'b0;
            d = data_in;
            v = valid_in;
        end
    endtask
    task hold_select(input integer n);
        begin
            @(posedge clk_in);
            #1;
            sel_bar_out = 1'b0;
            repeat (n) @(posedge clk_in);
            #1;
            sel_bar_out = 1'b1;
        end
    endtask
endmodule

// ==== verif/tb_io_misc_status_flags.sv ====
/* Testbench for the flag group: sets, keeps and clears each flag.
   Assumes the host model drives select and read strobe. */
`timescale 1ns/1ns
module tb_io_misc_status_flags;
    localparam integer SEL = 20;
    localparam integer ITO = 10;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg [4:0]  lvl = 5'h00; // Short3, short2, uv2, ov1, hot0
    reg [4:0]  ev = 5'h00;  // Parity, spi wake, forced, lp off, reset req
    reg [3:0]  wk = 4'h0;
    reg        lp_on = 1'b0, flash = 1'b0, intr = 1'b0, rmode = 1'b0, debug_on = 1'b0, pin_low = 1'b0;
    reg [15:0] per = 16'h0064;
    reg [15:0] el = 16'h0000, d;
    reg        v;
    wire       stb, sel_n, vld;
    wire [15:0] rdata, flags;
    integer    err_count = 0, n_checks = 0, k;
    iomsf_host_model host (.clk_in(clk), .data_in(rdata), .valid_in(vld), .read_stb_out(stb), .sel_bar_out(sel_n));
    iomsf_flags #(.SEL_STUCK_CYC(SEL), .INT_TIMEOUT_CYC(ITO), .WD_W(16)) DUT (
        .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .HIGH_SIDE_SWITCH3_SHORT_IN(lvl[0]),
        .HIGH_SIDE_SWITCH2_SHORT_IN(lvl[1]), .SPI_PARITY_ERR_IN(ev[0]), .SPI_SELECT_BAR_IN(sel_n),
        .BATTERY_SUPPLY_TWO_LOW_IN(lvl[2]), .BATTERY_SUPPLY_ONE_HIGH_IN(lvl[3]), .HIGH_SIDE_SWITCH0_HOT_IN(lvl[4]),
        .FLASH_MODE_IN(flash), .WD_ELAPSED_IN(el), .WD_PERIOD_IN(per), .WAKE_IO_IN(wk),
        .SPI_WAKE_IN(ev[1]), .LOW_POWER_REGULATOR_ON_IN(lp_on), .FORCED_WAKE_IN(ev[2]), .INT_ASSERTED_IN(intr),
        .LOW_POWER_REGULATOR_OFF_IN(ev[3]), .SPI_RESET_REQ_IN(ev[4]), .RESET_MODE_IN(rmode),
        .DEBUG_MODE_IN(debug_on), .DEBUG_ENTRY_PIN_LOW_IN(pin_low), .READ_STB_IN(stb),
        .FLAGS_OUT(flags), .READ_DATA_OUT(rdata), .READ_VALID_OUT(vld));
    initial forever #25 clk = ~clk;
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task t(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task rd_chk(input [15:0] exp);
        begin
            host.read_flags(d, v);
            chk(d, exp);
        end
    endtask
    task pulse(input [4:0] e, input [3:0] w);
        begin
            t(1);
            ev = e;
            wk = w;
            t(1);
            ev = 5'h00;
            wk = 4'h0;
        end
    endtask
    task s_level;
        begin
            lvl = 5'h1f;
            t(2);
            chk(flags, 16'h0073);
            rd_chk(16'h0073);
            chk({15'h0000, v}, 16'h0001);
            lvl = 5'h00;
            rd_chk(16'h0073);
            chk(flags, 16'h0000);
            rd_chk(16'h0000);
        end
    endtask
    task s_events;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                pulse(5'h00, 4'h1 << k);
                rd_chk((k % 2) ? 16'h0100 : 16'h0200);
            end
            rd_chk(16'h0000);
            lp_on = 1'b1;
            pulse(5'h0f, 4'h0);
            lp_on = 1'b0;
            rd_chk(16'h2c04);
            pulse(5'h02, 4'h0);
            rd_chk(16'h0000);
            fork
                host.read_flags(d, v);
                pulse(5'h01, 4'h0);
            join
            chk(d, 16'h0000);
            rd_chk(16'h0004);
        end
    endtask
    task s_stretch;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                host.hold_select(k ? SEL + 6 : SEL - 4);
                rd_chk(k ? 16'h0008 : 16'h0000);
                intr = 1'b1;
                t(k ? ITO + 6 : ITO - 4);
                intr = 1'b0;
                rd_chk(k ? 16'h1000 : 16'h0000);
            end
        end
    endtask
    task s_wd_mode;
        begin
            el = 16'h003c;
            t(2);
            rd_chk(16'h0000);
            el = 16'h0028;
            t(1);
            flash = 1'b1;
            el = 16'h0032;
            t(2);
            rd_chk(16'h0000);
            el = 16'h0033;
            t(2);
            flash = 1'b0;
            rd_chk(16'h0080);
            per = 16'h0020;
            el = 16'h0010;
            flash = 1'b1;
            t(2);
            rd_chk(16'h0000);
            el = 16'h0011;
            t(2);
            flash = 1'b0;
            rd_chk(16'h0080);
            rmode = 1'b1;
            t(3);
            rmode = 1'b0;
            debug_on = 1'b1;
            t(3);
            debug_on = 1'b0;
            t(2);
            rd_chk(16'h0000);
            pulse(5'h10, 4'h0);
            rmode = 1'b1;
            t(3);
            rmode = 1'b0;
            debug_on = 1'b1;
            pin_low = 1'b1;
            t(3);
            debug_on = 1'b0;
            t(2);
            rd_chk(16'hc000);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        t(20);
        rst = 1'b0;
        s_level;
        s_events;
        s_stretch;
        s_wd_mode;
        tally_and_finish;
    end
    initial begin
        #300000;
        err_count = err_count + 1;
        tally_and_finish;
    end
endmodule
